// ==== rtl/mcf_filter.v ====
`include "mcf_map.vh"

module mcf_filter (
	// Clock and reset.
	input  wire        MCLK,
	input  wire        SYS_RST,
	// Strap pins.
	input  wire        AUTO_MODE_STRAP,
	input  wire        CRC_FILTER_STRAP,
	// Received maintenance bits, M1 in bit 5.
	input  wire [5:0]  MAINT_BITS,
	input  wire        MAINT_VALID,
	input  wire        SUPERFRAME_START,
	input  wire        CRC_GOOD,
	// Transceiver status.
	input  wire        RX_SYNC,
	input  wire        DEACT_ENTRY,
	input  wire        POWERDOWN_EXIT,
	// Filter register access.
	input  wire        REG_WR,
	input  wire [7:0]  REG_WDATA,
	output wire [7:0]  REG_RDATA,
	output wire [7:0]  ACTIVE_FILTER,
	// Operations-word message.
	output reg         OPWORD_MSG_VALID,
	output reg  [11:0] OPWORD_MSG,
	output wire        RETURN_RX_EN,
	// Overhead-bit message.
	output reg         OVERHEAD_MSG_VALID,
	output reg  [11:0] OVERHEAD_MSG,
	// Approved status bits towards the state machine.
	output reg  [7:0]  FSM_STATUS_BITS
);

	// ------------------------------------------------------------------
	// Strap synchronisers and one-time preset.
	// ------------------------------------------------------------------
	reg  [1:0] auto_sync_reg;
	reg  [1:0] crc_sync_reg;
	reg  [1:0] strap_cnt_reg;
	reg        strap_done_reg;
	reg  [7:0] filt_reg;
	reg  [7:0] act_reg;
	wire       strap_load = !strap_done_reg && (strap_cnt_reg == `MCF_STRAP_WAIT);
	wire [7:0] strap_val  = {(crc_sync_reg[1] ? `MCF_CRC_STRAP_HI : `MCF_CRC_STRAP_LO),
		(auto_sync_reg[1] ? `MCF_EOC_AUTO : `MCF_EOC_TRANSP)};

	always @(posedge MCLK) begin
		auto_sync_reg <= {auto_sync_reg[0], AUTO_MODE_STRAP};
		crc_sync_reg  <= {crc_sync_reg[0], CRC_FILTER_STRAP};
		if (SYS_RST) begin
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			filt_reg       <= `MCF_FILT_RESET;
			act_reg        <= `MCF_FILT_RESET;
		end else begin
			if (!strap_done_reg)
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_load) begin
				strap_done_reg <= 1'b1;
				filt_reg       <= strap_val;
				act_reg        <= strap_val;
			end else begin
				if (REG_WR)
					filt_reg <= REG_WDATA;
				if (DEACT_ENTRY)
					act_reg <= REG_WR ? REG_WDATA : filt_reg;
			end
		end
	end

	assign REG_RDATA     = filt_reg;
	assign ACTIVE_FILTER = act_reg;

	wire [2:0] eoc_mode = act_reg[`MCF_EOC_MSB:`MCF_EOC_LSB];
	wire [1:0] m4_mode  = act_reg[`MCF_M4_MSB:`MCF_M4_LSB];
	wire       fsm_sel  = act_reg[`MCF_FSM_SEL_BIT];
	wire       m56_chg  = act_reg[`MCF_M56_BIT];

	assign RETURN_RX_EN = (eoc_mode == `MCF_EOC_AUTO);

	// ------------------------------------------------------------------
	// Frame assembly.
	// ------------------------------------------------------------------
	reg  [2:0]  frame_reg;
	reg  [11:0] eow_sh_reg;
	reg  [11:0] oh_sh_reg;
	wire [2:0]  frame_idx = SUPERFRAME_START ? 3'h0 : frame_reg;
	wire [11:0] eow_next  = {eow_sh_reg[8:0], MAINT_BITS[5:3]};
	wire        word_done = MAINT_VALID && (frame_idx[1:0] == 2'h3);
	wire        sf_done   = MAINT_VALID && (frame_idx == `MCF_LAST_FRAME);
	reg  [11:0] oh_next;

	always @* begin
		oh_next = oh_sh_reg;
		if (frame_idx == 3'h0)
			oh_next[11:9] = MAINT_BITS[2:0];
		else if (frame_idx == 3'h1)
			oh_next[8:6] = MAINT_BITS[2:0];
		else
			oh_next[3'h7 - frame_idx] = MAINT_BITS[2];
	end

	always @(posedge MCLK) begin
		if (SYS_RST) begin
			frame_reg  <= 3'h0;
			eow_sh_reg <= 12'h000;
			oh_sh_reg  <= `MCF_OH_ONES;
		end else if (MAINT_VALID) begin
			frame_reg  <= frame_idx + 3'h1;
			eow_sh_reg <= eow_next;
			oh_sh_reg  <= oh_next;
		end
	end

	// ------------------------------------------------------------------
	// Operations-word filter.
	// ------------------------------------------------------------------
	reg  [11:0] eow_last_reg;
	reg  [11:0] eow_rep_reg;
	reg  [1:0]  eow_cnt_reg;
	wire [1:0]  eow_cnt_next = (eow_next == eow_last_reg) ?
		((eow_cnt_reg == `MCF_TLL_COUNT) ? eow_cnt_reg : eow_cnt_reg + 2'h1) : 2'h1;
	reg         eow_emit;

	always @* begin
		case (eoc_mode)
			`MCF_EOC_TRANSP: eow_emit = 1'b1;
			`MCF_EOC_ONCHG:  eow_emit = (eow_next != eow_last_reg);
			`MCF_EOC_TLL,
			`MCF_EOC_AUTO:   eow_emit = (eow_cnt_next == `MCF_TLL_COUNT) &&
				(eow_next != eow_rep_reg);
			default:         eow_emit = 1'b0;
		endcase
	end

	always @(posedge MCLK) begin
		if (SYS_RST) begin
			eow_last_reg     <= 12'h000;
			eow_rep_reg      <= 12'h000;
			eow_cnt_reg      <= 2'h0;
			OPWORD_MSG_VALID <= 1'b0;
			OPWORD_MSG       <= 12'h000;
		end else begin
			OPWORD_MSG_VALID <= 1'b0;
			if (word_done) begin
				eow_last_reg <= eow_next;
				eow_cnt_reg  <= eow_cnt_next;
				if (eow_emit && RX_SYNC) begin
					eow_rep_reg      <= eow_next;
					OPWORD_MSG_VALID <= 1'b1;
					OPWORD_MSG       <= eow_next;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Overhead-bit filter, one slice per bit.
	// ------------------------------------------------------------------
	reg  [11:0] pend_reg;
	reg         pend_v_reg;
	reg  [11:0] acc_reg;
	reg  [11:0] last_a_reg;
	reg  [11:0] last_b_reg;
	reg  [23:0] cnt_a_reg;
	reg  [23:0] cnt_b_reg;
	wire [11:0] acc_next;
	wire [11:0] tll_a;
	wire [23:0] cnt_a_next;
	wire [23:0] cnt_b_next;
	wire [11:0] m4_mask = `MCF_M4_MASK;

	function [1:0] mcf_sat;
		input       same;
		input [1:0] cnt;
		begin
			mcf_sat = same ? ((cnt == `MCF_TLL_COUNT) ? cnt : cnt + 2'h1) : 2'h1;
		end
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_bit
			wire       is_m4 = m4_mask[gi];
			wire       chg   = !is_m4 && (m56_chg || gi == `MCF_FAR_END_BLOCK_ERROR_BIT_POS);
			wire [1:0] mode  = chg ? `MCF_OH_ONCHG :
				(is_m4 ? m4_mode : {1'b0, m4_mode[0]});
			wire       crc_v = pend_v_reg && CRC_GOOD;
			reg        ok;
			reg        val;
			assign cnt_a_next[2*gi+1:2*gi] = mcf_sat(oh_next[gi] == last_a_reg[gi],
				cnt_a_reg[2*gi+1:2*gi]);
			assign cnt_b_next[2*gi+1:2*gi] = crc_v ? mcf_sat(pend_reg[gi] == last_b_reg[gi],
				cnt_b_reg[2*gi+1:2*gi]) : 2'h0;
			assign tll_a[gi] = (cnt_a_next[2*gi+1:2*gi] == `MCF_TLL_COUNT);
			always @* begin
				case (mode)
					`MCF_OH_ONCHG: begin
						ok  = 1'b1;
						val = oh_next[gi];
					end
					`MCF_OH_TLL: begin
						ok  = tll_a[gi];
						val = oh_next[gi];
					end
					`MCF_OH_CRC: begin
						ok  = crc_v;
						val = pend_reg[gi];
					end
					default: begin
						ok  = (cnt_b_next[2*gi+1:2*gi] == `MCF_TLL_COUNT);
						val = pend_reg[gi];
					end
				endcase
			end
			assign acc_next[gi] = ok ? val : acc_reg[gi];
		end
	endgenerate

	wire [7:0] m4_pick_acc = {acc_next[11], acc_next[8], acc_next[5:0]};
	wire [7:0] m4_pick_new = {oh_next[11], oh_next[8], oh_next[5:0]};
	wire [7:0] m4_pick_tll = {tll_a[11], tll_a[8], tll_a[5:0]};
	wire [7:0] fsm_next;

	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_fsm
			assign fsm_next[gi] = fsm_sel ? m4_pick_acc[gi] :
				(m4_pick_tll[gi] ? m4_pick_new[gi] : FSM_STATUS_BITS[gi]);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Overhead state, status bits and message register.
	// ------------------------------------------------------------------

	always @(posedge MCLK) begin
		if (SYS_RST) begin
			pend_reg           <= `MCF_OH_ONES;
			pend_v_reg         <= 1'b0;
			acc_reg            <= `MCF_OH_ONES;
			last_a_reg         <= `MCF_OH_ONES;
			last_b_reg         <= `MCF_OH_ONES;
			cnt_a_reg          <= 24'h000000;
			cnt_b_reg          <= 24'h000000;
			FSM_STATUS_BITS    <= 8'hFF;
			OVERHEAD_MSG_VALID <= 1'b0;
			OVERHEAD_MSG       <= `MCF_OH_ONES;
		end else begin
			OVERHEAD_MSG_VALID <= 1'b0;
			if (POWERDOWN_EXIT) begin
				pend_reg        <= `MCF_OH_ONES;
				pend_v_reg      <= 1'b0;
				acc_reg         <= `MCF_OH_ONES;
				last_a_reg      <= `MCF_OH_ONES;
				last_b_reg      <= `MCF_OH_ONES;
				cnt_a_reg       <= 24'h000000;
				cnt_b_reg       <= 24'h000000;
				FSM_STATUS_BITS <= 8'hFF;
				OVERHEAD_MSG    <= `MCF_OH_ONES;
			end else if (sf_done) begin
				pend_reg        <= oh_next;
				pend_v_reg      <= 1'b1;
				last_a_reg      <= oh_next;
				last_b_reg      <= pend_reg;
				cnt_a_reg       <= cnt_a_next;
				cnt_b_reg       <= cnt_b_next;
				FSM_STATUS_BITS <= fsm_next;
				if (RX_SYNC) begin
					acc_reg <= acc_next;
					if (acc_next != acc_reg) begin
						OVERHEAD_MSG_VALID <= 1'b1;
						OVERHEAD_MSG       <= acc_next;
					end
				end
			end
		end
	end

endmodule

// ==== rtl/mcf_map.vh ====
`ifndef MCF_MAP_VH
`define MCF_MAP_VH

// ----------------------------------------------------------------------
// Filter register fields.
// ----------------------------------------------------------------------
`define MCF_EOC_LSB       0
`define MCF_EOC_MSB       2
`define MCF_M4_LSB        3
`define MCF_M4_MSB        4
`define MCF_FSM_SEL_BIT   5
`define MCF_M56_BIT       6
`define MCF_FILT_RESET    8'h00

// ----------------------------------------------------------------------
// Operations-word filter codes.
// ----------------------------------------------------------------------
`define MCF_EOC_AUTO      3'h4
`define MCF_EOC_TRANSP    3'h1
`define MCF_EOC_ONCHG     3'h2
`define MCF_EOC_TLL       3'h3

// ----------------------------------------------------------------------
// Overhead-bit filter codes.
// ----------------------------------------------------------------------
`define MCF_OH_ONCHG      2'h0
`define MCF_OH_TLL        2'h1
`define MCF_OH_CRC        2'h2
`define MCF_OH_CRC_TLL    2'h3

// ----------------------------------------------------------------------
// Strap presets and frame layout.
// ----------------------------------------------------------------------
`define MCF_CRC_STRAP_HI  5'h06
`define MCF_CRC_STRAP_LO  5'h00
`define MCF_STRAP_WAIT    2'h3
`define MCF_LAST_FRAME    3'h7
`define MCF_TLL_COUNT     2'h3
`define MCF_M4_MASK       12'h93F
`define MCF_FAR_END_BLOCK_ERROR_BIT_POS      6
`define MCF_OH_ONES       12'hFFF

`endif

// ==== testbench/mcf_line_model.sv ====
// ----------------------------------------------------------------------
// Line side: sends one superframe of eight basic frames on request.
// ----------------------------------------------------------------------
module mcf_line_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [47:0] sf,
	output logic      [5:0]  bits,
	output logic             valid,
	output logic             first,
	output logic             busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_reg;
	always @(posedge clk) begin
		valid <= 1'b0;
		first <= 1'b0;
		if (rst) begin
			cnt_reg <= 5'h00;
			busy    <= 1'b0;
			bits    <= 6'h3F;
		end else if (go && !busy) begin
			busy    <= 1'b1;
			cnt_reg <= 5'h00;
		end else if (busy) begin
			cnt_reg <= cnt_reg + 5'h01;
			if (cnt_reg[1:0] == 2'h0) begin
				bits  <= sf[47 - 6 * cnt_reg[4:2] -: 6];
				valid <= 1'b1;
				first <= (cnt_reg == 5'h00);
			end else begin
				bits <= ~bits;
			end
			if (cnt_reg == 5'h1F) begin
				busy <= 1'b0;
			end
		end
	end
endmodule

// ==== testbench/mcf_filter_checker.sv ====
module mcf_filter_checker (
	input wire logic       MCLK, SYS_RST, MAINT_VALID, RX_SYNC, DEACT_ENTRY, POWERDOWN_EXIT,
	input wire logic       REG_WR, OPWORD_MSG_VALID, OVERHEAD_MSG_VALID,
	input wire logic [7:0] REG_WDATA, REG_RDATA, ACTIVE_FILTER, FSM_STATUS_BITS
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	a_opword_pulse: assert property (OPWORD_MSG_VALID |=> !OPWORD_MSG_VALID)
		else $error("opword valid too long");
	a_opword_cause: assert property (OPWORD_MSG_VALID |-> $past(MAINT_VALID) && $past(RX_SYNC))
		else $error("opword without synced frame");
	a_overhead_cause: assert property (OVERHEAD_MSG_VALID |-> $past(MAINT_VALID) && $past(RX_SYNC))
		else $error("overhead without synced frame");
	a_overhead_pulse: assert property (OVERHEAD_MSG_VALID |=> !OVERHEAD_MSG_VALID)
		else $error("overhead valid too long");
	a_reg_write: assert property (REG_WR |=> REG_RDATA == $past(REG_WDATA))
		else $error("filter write lost");
	a_filter_held: assert property ($changed(ACTIVE_FILTER) && !$past(DEACT_ENTRY) |-> ACTIVE_FILTER == REG_RDATA)
		else $error("filter applied early");
	a_deact_apply: assert property (DEACT_ENTRY && !REG_WR |=> ACTIVE_FILTER == $past(REG_RDATA))
		else $error("filter not applied");
	a_pd_ones: assert property (POWERDOWN_EXIT && !MAINT_VALID |=> FSM_STATUS_BITS == 8'hFF)
		else $error("status bits not ones");
endmodule

// ==== testbench/mcf_filter_bench.sv ====
module mcf_filter_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, sys_rst = 1, auto_strap = 0, crc_strap = 0, rx_sync = 1, crc_good = 0;
	logic deact = 0, pd_exit = 0, reg_wr = 0, go = 0;
	logic [7:0] wdata = 8'h00, cur = 8'h01;
	logic [47:0] sf = 48'h0;
	wire [5:0] bits;
	wire valid, first, opv, ohv, rx_en;
	wire [7:0] rdata, active, fsm_bits;
	wire [11:0] opw, ohw;
	int n_errors = 0, n_compared = 0, cycles = 0;
	logic [11:0] op_q[$], oh_q[$];
	mcf_line_model line_u (.clk(mclk), .rst(sys_rst), .go(go), .sf(sf), .bits(bits),
		.valid(valid), .first(first), .busy());
	mcf_filter dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .AUTO_MODE_STRAP(auto_strap),
		.CRC_FILTER_STRAP(crc_strap), .MAINT_BITS(bits), .MAINT_VALID(valid),
		.SUPERFRAME_START(first), .CRC_GOOD(crc_good), .RX_SYNC(rx_sync), .DEACT_ENTRY(deact),
		.POWERDOWN_EXIT(pd_exit), .REG_WR(reg_wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.ACTIVE_FILTER(active), .OPWORD_MSG_VALID(opv), .OPWORD_MSG(opw), .RETURN_RX_EN(rx_en),
		.OVERHEAD_MSG_VALID(ohv), .OVERHEAD_MSG(ohw), .FSM_STATUS_BITS(fsm_bits));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (opv) op_q.push_back(opw);
		if (ohv) oh_q.push_back(ohw);
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task check(string what, logic [11:0] seen, logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task do_reset(logic a, logic c);
		auto_strap = a;
		crc_strap = c;
		sys_rst = 1;
		tick(16);
		sys_rst = 0;
		tick(6);
	endtask
	function logic [47:0] mk(logic [11:0] w1, logic [11:0] w2, logic [11:0] oh);
		for (int i = 0; i < 8; i++) begin
			logic [11:0] w;
			w = (i < 4) ? w1 : w2;
			mk[47 - 6 * i -: 3] = w[11 - 3 * (i % 4) -: 3];
			mk[44 - 6 * i -: 3] = (i < 2) ? oh[11 - 3 * i -: 3] : {oh[7 - i], 2'b11};
		end
	endfunction
	task send(logic [11:0] w1, logic [11:0] w2, logic [11:0] oh, int nop, int noh);
		op_q.delete();
		oh_q.delete();
		sf = mk(w1, w2, oh);
		go = 1;
		tick(1);
		go = 0;
		tick(40);
		check("opword count", 12'(op_q.size()), 12'(nop));
		check("overhead count", 12'(oh_q.size()), 12'(noh));
	endtask
	task write_filter(logic [7:0] v);
		wdata = v;
		reg_wr = 1;
		tick(1);
		reg_wr = 0;
		check("filter reg", rdata, v);
		check("filter held", active, cur);
		deact = 1;
		tick(1);
		deact = 0;
		check("filter applied", active, v);
		cur = v;
	endtask
	task test_straps();
		do_reset(0, 0);
		check("strap low", rdata, 8'h01);
		check("strap low active", active, 8'h01);
		check("return rx off", rx_en, 0);
		auto_strap = 1;
		crc_strap = 1;
		tick(8);
		check("strap once", rdata, 8'h01);
		do_reset(1, 1);
		check("strap high", rdata, 8'h34);
		check("return rx on", rx_en, 1);
		do_reset(0, 0);
		$display("straps test done");
	endtask
	task test_transparent();
		send(12'h123, 12'h456, 12'hA5A, 2, 1);
		check("word one", op_q[0], 12'h123);
		check("word two", op_q[1], 12'h456);
		check("overhead", oh_q[0], 12'hA5A);
		send(12'h123, 12'h456, 12'hA5A, 2, 0);
		rx_sync = 0;
		send(12'h789, 12'hABC, 12'h5A5, 0, 0);
		rx_sync = 1;
		pd_exit = 1;
		tick(1);
		pd_exit = 0;
		check("status ones", fsm_bits, 8'hFF);
		send(12'h123, 12'h456, 12'hA5A, 2, 1);
		$display("transparent test done");
	endtask
	task test_filters();
		logic [11:0] y;
		write_filter(8'h02);
		send(12'h111, 12'h111, 12'hA5A, 1, 0);
		check("changed word", op_q[0], 12'h111);
		send(12'h111, 12'h111, 12'hA5A, 0, 0);
		for (int c = 3; c < 5; c++) begin
			write_filter(8'(c));
			check("return rx", rx_en, c == 4);
			y = 12'h200 + 12'(c);
			send(y, y, 12'hA5A, 0, 0);
			send(y, 12'h0FF, 12'hA5A, 1, 0);
			check("repeated word", op_q[0], y);
		end
		$display("filter test done");
	endtask
	task test_overhead();
		write_filter(8'h0A);
		send(12'h0FF, 12'h0FF, 12'h5A5, 0, 1);
		check("far_end_block_error_bit on change", oh_q[0], 12'hA1A);
		send(12'h0FF, 12'h0FF, 12'h5A5, 0, 0);
		check("status not yet", fsm_bits, 8'h9A);
		send(12'h0FF, 12'h0FF, 12'h5A5, 0, 1);
		check("repeated bits", oh_q[0], 12'h5A5);
		check("status approved", fsm_bits, 8'h65);
		write_filter(8'h12);
		crc_good = 1;
		send(12'h0FF, 12'h0FF, 12'hA5A, 0, 1);
		check("m56 without crc", oh_q[0], 12'h365);
		send(12'h0FF, 12'h0FF, 12'hA5A, 0, 1);
		check("crc delayed", oh_q[0], 12'hA5A);
		$display("overhead test done");
	endtask
	initial begin
		test_straps();
		test_transparent();
		test_filters();
		test_overhead();
		end_of_test();
	end
endmodule
bind mcf_filter mcf_filter_checker chk_u (.*);
